//--- core/trr_memory_type_byte_combine.sv
// Attribute and shareability selection for a completed translation
`timescale 1ns/1ps
module trr_memory_type_byte_combine
   import trr_pkg::*;
(
   input wire logic [1:0] kind,
   input wire logic [7:0] s1_memory_type_byte,
   input wire logic [1:0] s1_sh,
   input wire logic [7:0] s2_memory_type_byte,
   input wire logic [1:0] s2_sh,
   output logic [7:0] memory_type_byte,
   output logic [1:0] sh
);
   // Device memory has a zero upper nibble in the indirection format
   function automatic logic is_device(input logic [7:0] a);
      return a[7:4] == 4'h0;
   endfunction

   // Stage-2 attributes carry forced allocate and transient hints
   wire logic [7:0] s2_forced;
   assign s2_forced = is_device(s2_memory_type_byte) ? s2_memory_type_byte :
                      {s2_memory_type_byte[7:4], (s2_memory_type_byte[3:0] & ~TRR_S2_HINT_MASK) | TRR_S2_HINT_VAL};
   // Combination: device beats normal, weaker cacheability wins nibble-wise
   wire logic [7:0] comb_memory_type_byte;
   assign comb_memory_type_byte = is_device(s2_memory_type_byte) ? s2_memory_type_byte :
                      is_device(s1_memory_type_byte) ? s1_memory_type_byte :
                      {(s1_memory_type_byte[7:4] < s2_memory_type_byte[7:4]) ? s1_memory_type_byte[7:4] : s2_memory_type_byte[7:4],
                       (s1_memory_type_byte[3:0] < s2_memory_type_byte[3:0]) ? s1_memory_type_byte[3:0] : s2_memory_type_byte[3:0]};
   wire logic [1:0] comb_sh;
   assign comb_sh = (s1_sh > s2_sh) ? s1_sh : s2_sh;
   // Table values only; per-stream overrides never reach this path
   wire logic [7:0] sel_memory_type_byte;
   assign sel_memory_type_byte = (kind == TRR_KIND_S2) ? s2_forced :
                     (kind == TRR_KIND_BOTH) ? comb_memory_type_byte : s1_memory_type_byte;
   wire logic [1:0] sel_sh;
   assign sel_sh = (kind == TRR_KIND_S2) ? s2_sh : (kind == TRR_KIND_BOTH) ? comb_sh : s1_sh;
   assign memory_type_byte = sel_memory_type_byte;
   // Device types report outer; reserved encoding is never returned
   assign sh = is_device(sel_memory_type_byte) ? TRR_SH_OUTER :
               (sel_sh == TRR_SH_RSVD) ? TRR_SH_NON : sel_sh;
endmodule // trr_memory_type_byte_combine

//--- core/trr_pkg.sv
// Package for the translation result reporting block: offsets, fields, encodings
package trr_pkg;
   // Register map
   localparam logic [11:0] TRR_RESULT_OFFSET = 12'h118;
   // Result word field positions
   localparam int TRR_FAULT_BIT = 0;
   localparam int TRR_REASON_LSB = 1;
   localparam int TRR_SH_LSB = 8;
   localparam int TRR_SIZE_BIT = 11;
   localparam int TRR_CODE_LSB = 4;
   localparam int TRR_ADDR_LSB = 12;
   localparam int TRR_ADDR_MSB = 51;
   localparam int TRR_ADDR_W = 40;
   localparam int TRR_V30_HI_LSB = 48;
   localparam int TRR_MEMORY_TYPE_BYTE_LSB = 56;
   localparam int TRR_VEND_LSB = 60;
   localparam int TRR_SIZE_LOG_MIN = 12;
   localparam int TRR_SIZE_LOG_MAX = 52;
   // Reset value of the result word
   localparam logic [63:0] TRR_RESULT_RESET = 64'h0;
   // Shareability encodings
   localparam logic [1:0] TRR_SH_NON = 2'h0;
   localparam logic [1:0] TRR_SH_RSVD = 2'h1;
   localparam logic [1:0] TRR_SH_OUTER = 2'h2;
   localparam logic [1:0] TRR_SH_INNER = 2'h3;
   // Request kind encodings
   localparam logic [1:0] TRR_KIND_RSVD = 2'h0;
   localparam logic [1:0] TRR_KIND_S1 = 2'h1;
   localparam logic [1:0] TRR_KIND_S2 = 2'h2;
   localparam logic [1:0] TRR_KIND_BOTH = 2'h3;
   // Error codes, values arbitrary
   localparam logic [7:0] TRR_CODE_INV_REQ = 8'h01;
   localparam logic [7:0] TRR_CODE_INTERNAL = 8'h02;
   // Stage-2 forced hint bits within the low nibble of an attribute byte
   localparam logic [3:0] TRR_S2_HINT_MASK = 4'h7;
   localparam logic [3:0] TRR_S2_HINT_VAL = 4'h3;

   // Translation walk outcome from the walker
   typedef struct packed {
      logic fault;
      logic [39:0] page;
      logic [5:0] size_log2;
      logic [7:0] s1_memory_type_byte;
      logic [1:0] s1_sh;
      logic [7:0] s2_memory_type_byte;
      logic [1:0] s2_sh;
      logic [7:0] err_code;
      logic [1:0] reason;
      logic [3:0] vendor_bits;
   } trr_walk_s;
endpackage

//--- core/trr_result_reg.sv
// Result register and formatter for software-initiated translation operations
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Bit 0 selects success or fault layout.
// - Success puts attribute byte in bits 63:56.
// - Success returns output page in bits 51:12.
// - Earliest revision zeroes address bits 51:48.
// - Bit 11 low for 4KB, else size-encoded.
// - Large sizes: zero low bits, mark bit N.
// - Shareability in 9:8; device memory reports outer.
// - Attributes from tables only, no stream overrides.
// - Stage-2 only forces allocate hints, clears transient.
// - Stage-1 attributes, or both stages combined.
// - May report cached attributes or sizes.
// - Fault: vendor bits 63:60, 59:52 and 3 zero.
// - Fault returns failing page in bits 51:12.
// - Fault code in 11:4, class in 2:1.
// - Result is unknown while operation runs.
// - Absent capability: reads zero, writes ignored.
// - Reserved request kind gives invalid-request error.
// - Disable mid-run: finish or abort with internal error.
//////////////////////////////////////////////////////////////////////////////////////////
module trr_result_reg
   import trr_pkg::*;
#(
   parameter bit ARCH_REV0 = 1'b0
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic op_capable,
   input wire logic unit_enable,
   input wire logic op_start,
   input wire logic [1:0] op_kind,
   input wire logic walk_done,
   input wire trr_pkg::trr_walk_s walk,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [11:0] reg_addr,
   output logic [63:0] reg_rdata,
   output logic reg_rvalid,
   output logic op_running,
   output logic walk_req,
   output logic walk_abort
);
   import trr_pkg::*;

   typedef enum logic [2:0] {
      TRR_IDLE = 3'b001,
      TRR_WALK = 3'b010,
      TRR_DONE = 3'b100
   } trr_state_e;

   //////////////////////////////////////////////////////////////////////////////////////
   // Request capture and state machine
   trr_state_e state_reg;
   trr_state_e state_next;
   logic [1:0] kind_reg;
   logic [63:0] result_reg;
   logic [63:0] result_next;
   logic load_result;
   logic running_reg;
   logic walk_req_reg;
   logic abort_reg;
   logic [63:0] rdata_reg;
   logic rvalid_reg;

   // Start only when capable, enabled and idle
   wire logic start_ok;
   assign start_ok = op_start && op_capable && unit_enable && (state_reg == TRR_IDLE);
   // Reserved kind never walks; it fails immediately
   wire logic kind_bad;
   assign kind_bad = (op_kind == TRR_KIND_RSVD);
   // Disable mid-walk aborts rather than waiting for the walker
   wire logic abort_now;
   assign abort_now = (state_reg == TRR_WALK) && !unit_enable && !walk_done;

   //////////////////////////////////////////////////////////////////////////////////////
   // Success record formatting
   logic [7:0] ok_memory_type_byte;
   logic [1:0] ok_sh;
   trr_memory_type_byte_combine u_combine (
      .kind(kind_reg),
      .s1_memory_type_byte(walk.s1_memory_type_byte),
      .s1_sh(walk.s1_sh),
      .s2_memory_type_byte(walk.s2_memory_type_byte),
      .s2_sh(walk.s2_sh),
      .memory_type_byte(ok_memory_type_byte),
      .sh(ok_sh)
   );

   // Clamp the reported size into the page field range
   wire logic [5:0] size_log;
   assign size_log = (walk.size_log2 < 6'(TRR_SIZE_LOG_MIN)) ? 6'(TRR_SIZE_LOG_MIN) :
                     (walk.size_log2 > 6'(TRR_SIZE_LOG_MAX)) ? 6'(TRR_SIZE_LOG_MAX) :
                     walk.size_log2;
   wire logic big_page;
   assign big_page = size_log > 6'(TRR_SIZE_LOG_MIN);

   // Per-bit mask and marker: bit N of the page field set where 2^(N+1) is the size
   logic [TRR_ADDR_W-1:0] low_mask;
   logic [TRR_ADDR_W-1:0] size_mark;
   genvar gi;
   generate
      for (gi = 0; gi < TRR_ADDR_W; gi++) begin : g_mask
         assign low_mask[gi] = (6'(gi + TRR_ADDR_LSB) < size_log);
         assign size_mark[gi] = big_page && (6'(gi + TRR_ADDR_LSB + 1) == size_log);
      end
   endgenerate

   // Address bits below the size are zeroed before the marker goes in
   wire logic [TRR_ADDR_W-1:0] ok_page;
   assign ok_page = (walk.page & ~low_mask) | size_mark;

   // Earliest revision holds the top four page bits low in both layouts
   function automatic logic [TRR_ADDR_W-1:0] rev_clip(input logic [TRR_ADDR_W-1:0] p);
      logic [TRR_ADDR_W-1:0] q;
      q = p;
      if (ARCH_REV0) begin
         q[TRR_ADDR_W-1:TRR_V30_HI_LSB-TRR_ADDR_LSB] = '0;
      end
      return q;
   endfunction

   wire logic [63:0] ok_word;
   assign ok_word = {ok_memory_type_byte,
                     4'h0,
                     rev_clip(ok_page),
                     big_page,
                     1'b0,
                     ok_sh,
                     7'h00,
                     1'b0};

   //////////////////////////////////////////////////////////////////////////////////////
   // Fault syndrome formatting
   function automatic logic [63:0] fault_word(input logic [3:0] vb, input logic [39:0] pg,
                                              input logic [7:0] code, input logic [1:0] rsn);
      return {vb, 8'h00, rev_clip(pg), code, 1'b0, rsn, 1'b1};
   endfunction

   wire logic [63:0] walk_fault_word;
   assign walk_fault_word = fault_word(walk.vendor_bits, walk.page, walk.err_code,
                                       walk.reason);
   wire logic [63:0] inv_word;
   assign inv_word = fault_word(4'h0, '0, TRR_CODE_INV_REQ, 2'h0);
   wire logic [63:0] abort_word;
   assign abort_word = fault_word(4'h0, '0, TRR_CODE_INTERNAL, 2'h0);

   //////////////////////////////////////////////////////////////////////////////////////
   // Next state and result selection
   always_comb begin
      state_next = state_reg;
      result_next = result_reg;
      load_result = 1'b0;
      unique case (state_reg)
         TRR_IDLE: begin
            if (start_ok && kind_bad) begin
               result_next = inv_word;
               load_result = 1'b1;
               state_next = TRR_DONE;
            end else if (start_ok) begin
               state_next = TRR_WALK;
            end
         end
         TRR_WALK: begin
            if (walk_done) begin
               result_next = walk.fault ? walk_fault_word : ok_word;
               load_result = 1'b1;
               state_next = TRR_DONE;
            end else if (abort_now) begin
               result_next = abort_word;
               load_result = 1'b1;
               state_next = TRR_DONE;
            end
         end
         TRR_DONE: begin
            state_next = TRR_IDLE;
         end
         default: begin
            state_next = TRR_IDLE;
         end
      endcase
   end

   // Controller state
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_reg <= TRR_IDLE;
         kind_reg <= TRR_KIND_RSVD;
      end else if (clk_en) begin
         state_reg <= state_next;
         if (start_ok) begin
            kind_reg <= op_kind; // request latched; later changes cannot leak in
         end
      end
   end

   // Result word; written in the cycle before the run flag drops
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         result_reg <= TRR_RESULT_RESET;
      end else if (clk_en && load_result) begin
         result_reg <= result_next;
      end
   end

   // Run flag clears one cycle after the result lands
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         running_reg <= 1'b0;
         walk_req_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else if (clk_en) begin
         running_reg <= (state_next != TRR_IDLE);
         walk_req_reg <= (state_next == TRR_WALK);
         abort_reg <= abort_now;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Register read port; writes to this read-only word are dropped
   wire logic hit;
   assign hit = (reg_addr == TRR_RESULT_OFFSET) && op_capable;
   // Running reads return zero, one legal choice of the unknown value
   wire logic [63:0] rd_value;
   assign rd_value = (hit && !running_reg) ? result_reg : 64'h0;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_reg <= 64'h0;
         rvalid_reg <= 1'b0;
      end else if (clk_en) begin
         rvalid_reg <= reg_rd;
         if (reg_rd) begin
            rdata_reg <= rd_value;
         end
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign op_running = running_reg;
   assign walk_req = walk_req_reg;
   assign walk_abort = abort_reg;

   // Write strobe has no effect: result word is read-only
   wire logic unused_wr;
   assign unused_wr = reg_wr;
endmodule // trr_result_reg

//--- verif/trr_result_reg_bench.sv
// Self-checking bench for the translation result register
`timescale 1ns/1ps
module translation_result_reporting_bench;
   import trr_pkg::*;
   logic mclk = 0, rstn = 0, clk_en = 1, op_capable = 1, unit_enable = 1;
   logic op_start = 0, walk_done = 0, reg_rd = 0, reg_wr = 0;
   logic [1:0] op_kind = 2'h1;
   logic [11:0] reg_addr = TRR_RESULT_OFFSET;
   trr_walk_s walk = '0;
   logic [63:0] reg_rdata;
   logic reg_rvalid, op_running, walk_req, walk_abort;
   int err_total = 0, comparisons = 0;
   trr_result_reg #(.ARCH_REV0(1'b0)) u_dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
      .op_capable(op_capable), .unit_enable(unit_enable), .op_start(op_start),
      .op_kind(op_kind), .walk_done(walk_done), .walk(walk), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .op_running(op_running), .walk_req(walk_req), .walk_abort(walk_abort));
   // Clock at 200 MHz
   always begin
      #2.5 mclk = ~mclk;
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Success record: align page to the size, then mark bit N
   function automatic logic [63:0] ok(logic [7:0] at, logic [39:0] pg, int lg, logic [1:0] sh);
      logic [39:0] a;
      a = pg;
      if (lg > 12) begin
         a = (a >> (lg - 12)) << (lg - 12);
         a[lg - 13] = 1'b1;
      end
      return {at, 4'h0, a, lg > 12, 1'b0, sh, 8'h00};
   endfunction
   // One read strobe; answer is looked at the cycle after
   task automatic rd(input string nm, input logic [63:0] exp);
      @(posedge mclk) #1 reg_rd = 1;
      @(posedge mclk) #1 reg_rd = 0;
      chk("rvalid", reg_rvalid, 1'b1);
      chk(nm, reg_rdata, exp);
   endtask
   // Start, read while running, optionally finish the walk, then read back
   task automatic op(input logic [1:0] k, input trr_walk_s w, input bit fin, input logic [63:0] exp);
      @(posedge mclk) #1 op_start = 1;
      op_kind = k; // Held until the next start
      @(posedge mclk) #1 op_start = 0;
      // A reserved kind finishes before this read, so its result is already visible
      rd("busy", fin ? 64'h0 : exp);
      if (fin) begin
         walk = w;
         walk_done = 1;
         @(posedge mclk) #1 walk_done = 0;
      end
      for (int i = 0; i < 10 && op_running !== 1'b0; i++) @(posedge mclk) #1;
      chk("idle", op_running, 1'b0);
      rd("result", exp);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic s_success();
      trr_walk_s w;
      w = '0;
      w.page = 40'hA_BCDE_F123;
      w.size_log2 = 6'd12;
      w.s1_memory_type_byte = 8'hFF;
      w.s1_sh = TRR_SH_INNER;
      op(TRR_KIND_S1, w, 1, ok(8'hFF, w.page, 12, 2'b11));
      w.size_log2 = 6'd16;
      op(TRR_KIND_S1, w, 1, ok(8'hFF, w.page, 16, 2'b11));
      w.size_log2 = 6'd21;
      w.s1_memory_type_byte = 8'h08;
      w.s1_sh = TRR_SH_NON;
      op(TRR_KIND_S1, w, 1, ok(8'h08, w.page, 21, 2'b10));
      w.s2_memory_type_byte = 8'hF4;
      w.s2_sh = TRR_SH_OUTER;
      op(TRR_KIND_S2, w, 1, ok(8'hF3, w.page, 21, 2'b10));
      w.s1_memory_type_byte = 8'hFF;
      w.s1_sh = TRR_SH_OUTER;
      w.s2_memory_type_byte = 8'h44;
      w.s2_sh = TRR_SH_INNER;
      op(TRR_KIND_BOTH, w, 1, ok(8'h44, w.page, 21, 2'b11));
   endtask
   // Fault syndrome for every reason class
   task automatic s_fault();
      trr_walk_s w;
      w = '0;
      w.fault = 1;
      w.page = 40'h0_1234_5678;
      w.err_code = 8'hA5;
      w.vendor_bits = 4'h9;
      for (int r = 0; r < 4; r++) begin
         w.reason = r[1:0];
         op(TRR_KIND_BOTH, w, 1, {4'h9, 8'h0, w.page, 8'hA5, 1'b0, r[1:0], 1'b1});
      end
   endtask
   // Reserved kind, abort, and refused accesses
   task automatic s_refuse();
      op(TRR_KIND_RSVD, '0, 0, {52'h0, TRR_CODE_INV_REQ, 4'h1});
      @(posedge mclk) #1 op_start = 1;
      op_kind = TRR_KIND_S1;
      @(posedge mclk) #1 op_start = 0;
      unit_enable = 0;
      for (int i = 0; i < 10 && walk_abort !== 1'b1; i++) @(posedge mclk) #1;
      chk("abort", walk_abort, 1'b1);
      repeat (2) @(posedge mclk) #1;
      unit_enable = 1;
      rd("aborted", {52'h0, TRR_CODE_INTERNAL, 4'h1});
      reg_wr = 1;
      @(posedge mclk) #1 reg_wr = 0;
      rd("after write", {52'h0, TRR_CODE_INTERNAL, 4'h1});
      reg_addr = 12'h110;
      rd("other offset", 64'h0);
      reg_addr = TRR_RESULT_OFFSET;
      op_capable = 0;
      rd("incapable", 64'h0);
      op_capable = 1;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      #1 rstn = 1;
      rd("reset", TRR_RESULT_RESET);
      s_success();
      s_fault();
      s_refuse();
      stop_test();
   end
   // Watchdog well beyond the expected run
   initial begin
      #20000;
      err_total++;
      stop_test();
   end
endmodule // translation_result_reporting_bench

//--- verif/trr_result_reg_sva.sv
// Checker for the translation result register ports
`timescale 1ns/1ps
module trr_result_reg_sva
   import trr_pkg::*;
#(
   parameter bit ARCH_REV0 = 1'b0
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic op_capable,
   input wire logic unit_enable,
   input wire logic op_start,
   input wire logic [1:0] op_kind,
   input wire logic walk_done,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [63:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic op_running,
   input wire logic walk_req,
   input wire logic walk_abort
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Read answer timing and refused reads
   a_read_answer_due: assert property (reg_rd && clk_en |=> reg_rvalid) else $error("no read answer");
   a_run_read_zero: assert property (reg_rd && clk_en && op_running |=> reg_rdata == 64'h0) else $error("read in run not zero");
   a_absent_read_zero: assert property (reg_rd && clk_en && (!op_capable || reg_addr != TRR_RESULT_OFFSET) |=> reg_rdata == 64'h0) else $error("absent read not zero");
   // Layout reserved bits and device shareability
   a_ok_rsvd_zero: assert property (reg_rvalid && !reg_rdata[0] |-> reg_rdata[55:52] == 4'h0 && !reg_rdata[10] && reg_rdata[7:1] == 7'h0) else $error("success reserved set");
   a_fault_rsvd_zero: assert property (reg_rvalid && reg_rdata[0] |-> reg_rdata[59:52] == 8'h0 && !reg_rdata[3]) else $error("fault reserved set");
   a_device_outer_sh: assert property (reg_rvalid && !reg_rdata[0] && reg_rdata[63:60] == 4'h0 && reg_rdata[51:12] != 40'h0 |-> reg_rdata[9:8] == TRR_SH_OUTER) else $error("device not outer");
   a_rev0_hi_zero: assert property (reg_rvalid && ARCH_REV0 |-> reg_rdata[51:48] == 4'h0) else $error("rev0 high bits set");
   // Run flag sequencing
   a_start_sets_run: assert property (op_start && clk_en && op_capable && unit_enable && !op_running |=> op_running) else $error("run not set");
   a_done_then_clear: assert property (walk_done && walk_req && clk_en |=> !walk_req ##1 !op_running) else $error("run not cleared");
   a_abort_then_idle: assert property (walk_abort |=> !walk_abort && !op_running) else $error("abort not closed");
endmodule // trr_result_reg_sva
//////////////////////////////////////////////////////////////////////////////
bind trr_result_reg trr_result_reg_sva #(.ARCH_REV0(ARCH_REV0)) u_sva (.mclk(mclk), .rstn(rstn),
   .clk_en(clk_en), .op_capable(op_capable), .unit_enable(unit_enable), .op_start(op_start),
   .op_kind(op_kind), .walk_done(walk_done), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .op_running(op_running),
   .walk_req(walk_req), .walk_abort(walk_abort));
